// file: pkg/can_bt3_cfg.svh
`ifndef CAN_BT3_CFG_SVH
`define CAN_BT3_CFG_SVH

// ****************************************************************
// Register layout
// ****************************************************************
`define BT3_REG_ADDR    8'h28
`define BT3_RESET_VALUE 8'h00
`define BT3_WRITE_MASK  8'hc7
`define BT3_SOF_BIT     7
`define BT3_WAKE_BIT    6
`define BT3_SEG_MSB     2
`define BT3_SEG_LSB     0
`define BT3_GAP_MSB     5
`define BT3_GAP_LSB     3

// ****************************************************************
// Timing
// ****************************************************************
`define CORE_CLK_PERIOD_NS 25
`define WAKE_FILTER_NS     1000
`define AUX_CLOCK_DIV      4

`endif

// file: pkg/can_bt3_pkg.sv
package can_bt3_pkg;

	typedef enum logic [1:0] {
		SEG_IDLE = 2'b00,
		SEG_RUN  = 2'b01,
		SEG_DONE = 2'b11
	} seg_two_state_t;

	// Least time rounds up to whole cycles, never below one.
	function automatic int cycles_ceil(input int time_ns, input int period_ns);
		int n;
		n = (time_ns + period_ns - 1) / period_ns;
		return (n < 1) ? 1 : n;
	endfunction

endpackage

// file: design/wake_input_filter.sv
`include "can_bt3_cfg.svh"

module wake_input_filter
	import can_bt3_pkg::*;
#(
	parameter int FILTER_CYCLES = cycles_ceil(`WAKE_FILTER_NS, `CORE_CLK_PERIOD_NS)
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic filter_on,
	input  wire logic wake_level,
	output logic      wake_out
);

	generate
		if (FILTER_CYCLES < 1 || FILTER_CYCLES > 65535) begin : g_bad
			$error("wake_input_filter: FILTER_CYCLES out of range");
		end
	endgenerate

	logic [15:0] stable_cnt_reg;
	logic [15:0] stable_cnt_next;
	logic        wake_out_next;
	wire         differs = wake_level != wake_out;
	wire         settled = stable_cnt_reg == 16'(FILTER_CYCLES - 1);

	// A disabled filter passes the level straight through; an enabled one
	// needs the new level to hold for the whole filter time.
	assign stable_cnt_next = (!filter_on || !differs || settled) ? 16'h0000 : stable_cnt_reg + 16'h0001;
	assign wake_out_next   = (!filter_on || (differs && settled)) ? wake_level : wake_out;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stable_cnt_reg <= 16'h0000;
			wake_out       <= 1'b0;
		end else begin
			stable_cnt_reg <= stable_cnt_next;
			wake_out       <= wake_out_next;
		end
	end

endmodule

// file: design/can_bit_timing_config_three.sv
// Overview of operation
// - Enabled aux clock with frame marker select 1 puts start-of-frame on the pin.
// - Enabled aux clock with frame marker select 0 puts the divided clock on the pin.
// - With aux clock enable clear the select bit is ignored; the pin stays low.
// - Wake filter enable bit 6 switches the wake-up input filter on and off.
// - Bits 5 to 3 always read as zero.
// - Phase segment two lasts (bits 2 to 0 plus one) time quanta.
`include "can_bt3_cfg.svh"

module can_bit_timing_config_three
	import can_bt3_pkg::*;
#(
	parameter int AUX_DIV       = `AUX_CLOCK_DIV,
	parameter int FILTER_CYCLES = cycles_ceil(`WAKE_FILTER_NS, `CORE_CLK_PERIOD_NS)
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_wr_data,
	output logic      [7:0] reg_rd_data,
	input  wire logic       aux_clock_enable,
	input  wire logic       frame_start,
	output logic            aux_clock_pin,
	input  wire logic       wake_pin,
	output logic            wake_filter_on,
	output logic            wake_detect,
	input  wire logic       time_quantum_tick,
	input  wire logic       phase_two_start,
	output logic            phase_two_active,
	output logic            phase_two_done
);

	generate
		if (AUX_DIV < 2 || AUX_DIV > 65534 || (AUX_DIV % 2) != 0) begin : g_bad_div
			$error("can_bit_timing_config_three: AUX_DIV must be even and at least 2");
		end
	endgenerate

	// ****************************************************************
	// Configuration register
	// ****************************************************************
	// The read image is the storage flop itself; the unimplemented bits are
	// masked on write so they can never hold a one.
	logic [7:0] cfg_reg;
	wire  [7:0] cfg_next = reg_wr_en ? (reg_wr_data & `BT3_WRITE_MASK) : cfg_reg;

	wire       sof_select     = cfg_reg[`BT3_SOF_BIT];
	wire       wake_filter_en = cfg_reg[`BT3_WAKE_BIT];
	wire [2:0] phase_segment_two_length = cfg_reg[`BT3_SEG_MSB:`BT3_SEG_LSB];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_reg        <= `BT3_RESET_VALUE;
			wake_filter_on <= 1'b0;
		end else begin
			cfg_reg        <= cfg_next;
			wake_filter_on <= cfg_next[`BT3_WAKE_BIT];
		end
	end

	assign reg_rd_data = cfg_reg;

	// ****************************************************************
	// Auxiliary clock pin
	// ****************************************************************
	localparam int HALF_DIV = AUX_DIV / 2;

	logic [15:0] div_cnt_reg;
	logic        div_clk_reg;
	wire         div_wrap     = div_cnt_reg == 16'(HALF_DIV - 1);
	wire  [15:0] div_cnt_next = div_wrap ? 16'h0000 : div_cnt_reg + 16'h0001;
	wire         div_clk_next = div_wrap ? ~div_clk_reg : div_clk_reg;

	// Select bit only matters while the enable is set; otherwise the pin
	// parks low so a disabled output never shows a stray marker.
	wire pin_next = !aux_clock_enable ? 1'b0 :
	                sof_select        ? frame_start :
	                                    div_clk_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_cnt_reg   <= 16'h0000;
			div_clk_reg   <= 1'b0;
			aux_clock_pin <= 1'b0;
		end else begin
			div_cnt_reg   <= div_cnt_next;
			div_clk_reg   <= div_clk_next;
			aux_clock_pin <= pin_next;
		end
	end

	// ****************************************************************
	// Wake-up input
	// ****************************************************************
	// The pin is asynchronous, so it is synchronised before the filter.
	logic wake_meta_reg;
	logic wake_sync_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
		end else begin
			wake_meta_reg <= wake_pin;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	wake_input_filter #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_wake_filter (
		.core_clk  (core_clk),
		.rst       (rst),
		.filter_on (wake_filter_en),
		.wake_level(wake_sync_reg),
		.wake_out  (wake_detect)
	);

	// ****************************************************************
	// Phase segment two timer
	// ****************************************************************
	seg_two_state_t state_reg;
	seg_two_state_t state_next;
	logic [2:0]     quanta_left_reg;
	logic [2:0]     quanta_left_next;

	wire last_quantum = time_quantum_tick && quanta_left_reg == 3'h0;

	// The length is sampled at start, so a write during a running segment
	// takes effect from the next one.
	always_comb begin
		state_next       = state_reg;
		quanta_left_next = quanta_left_reg;
		case (state_reg)
			SEG_IDLE: begin
				if (phase_two_start) begin
					state_next       = SEG_RUN;
					quanta_left_next = phase_segment_two_length;
				end
			end
			SEG_RUN: begin
				if (phase_two_start) begin
					quanta_left_next = phase_segment_two_length;
				end else if (last_quantum) begin
					state_next = SEG_DONE;
				end else if (time_quantum_tick) begin
					quanta_left_next = quanta_left_reg - 3'h1;
				end
			end
			SEG_DONE: begin
				state_next = SEG_IDLE;
				if (phase_two_start) begin
					state_next       = SEG_RUN;
					quanta_left_next = phase_segment_two_length;
				end
			end
			default: begin
				state_next = SEG_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg        <= SEG_IDLE;
			quanta_left_reg  <= 3'h0;
			phase_two_active <= 1'b0;
			phase_two_done   <= 1'b0;
		end else begin
			state_reg        <= state_next;
			quanta_left_reg  <= quanta_left_next;
			phase_two_active <= state_next == SEG_RUN;
			phase_two_done   <= state_next == SEG_DONE;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	// Helper: quanta seen since the segment started, and length in use.
	logic [3:0] quanta_seen_reg;
	logic [2:0] len_used_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			quanta_seen_reg <= 4'h0;
			len_used_reg    <= 3'h0;
		end else if (state_next == SEG_RUN && state_reg != SEG_RUN) begin
			quanta_seen_reg <= 4'h0;
			len_used_reg    <= phase_segment_two_length;
		end else if (state_reg == SEG_RUN && phase_two_start) begin
			quanta_seen_reg <= 4'h0;
			len_used_reg    <= phase_segment_two_length;
		end else if (state_reg == SEG_RUN && time_quantum_tick) begin
			quanta_seen_reg <= quanta_seen_reg + 4'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sof_on_pin_a: assert property (
		(aux_clock_enable && sof_select) |=> aux_clock_pin == $past(frame_start))
		else $error("aux pin does not follow frame start");

	clk_on_pin_a: assert property (
		(aux_clock_enable && !sof_select) |=> aux_clock_pin == $past(div_clk_reg))
		else $error("aux pin does not follow divided clock");

	clk_period_a: assert property (
		$rose(div_clk_reg) |-> ##HALF_DIV $fell(div_clk_reg))
		else $error("divided clock half period wrong");

	pin_parked_a: assert property (
		!aux_clock_enable |=> !aux_clock_pin)
		else $error("aux pin driven while disabled");

	wake_filter_bit_a: assert property (
		reg_wr_en |=> wake_filter_on == $past(reg_wr_data[`BT3_WAKE_BIT]))
		else $error("wake filter enable not taken from write");

	wake_bypass_a: assert property (
		(!wake_filter_en && !$past(wake_filter_en)) |=> wake_detect == $past(wake_sync_reg))
		else $error("disabled filter does not pass the wake level");

	gap_zero_a: assert property (
		reg_rd_data[`BT3_GAP_MSB:`BT3_GAP_LSB] == 3'h0)
		else $error("unimplemented bits read nonzero");

	seg_two_length_a: assert property (
		(state_reg == SEG_RUN && last_quantum && !phase_two_start)
		|-> quanta_seen_reg == {1'b0, len_used_reg}
		##1 phase_two_done)
		else $error("phase segment two length wrong");

	sof_mode_c:    cover property (aux_clock_enable && sof_select && frame_start);
	clk_mode_c:    cover property (aux_clock_enable && !sof_select ##1 $rose(aux_clock_pin));
	wake_filter_c: cover property (wake_filter_en && $rose(wake_detect));
	seg_two_max_c: cover property (phase_segment_two_length == 3'h7 && $rose(phase_two_done));

endmodule

// file: tb/can_bit_timing_config_three_tb.sv
module can_bit_timing_config_three_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Stimulus and observation
	// ****************************************************************
	logic       core_clk, rst, reg_wr_en, aux_clock_enable, frame_start;
	logic       wake_pin, time_quantum_tick, phase_two_start;
	logic [7:0] reg_wr_data, reg_rd_data;
	logic       aux_clock_pin, wake_filter_on, wake_detect;
	logic       phase_two_active, phase_two_done, prev;
	int         num_errors, n_checks, cycles;

	// Short counts keep the run brief; expectations follow these values.
	can_bit_timing_config_three #(.AUX_DIV(2), .FILTER_CYCLES(3)) u_dut (
		.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.aux_clock_enable(aux_clock_enable), .frame_start(frame_start),
		.aux_clock_pin(aux_clock_pin), .wake_pin(wake_pin),
		.wake_filter_on(wake_filter_on), .wake_detect(wake_detect),
		.time_quantum_tick(time_quantum_tick), .phase_two_start(phase_two_start),
		.phase_two_active(phase_two_active), .phase_two_done(phase_two_done));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] d);
		@(negedge core_clk);
		reg_wr_en = 1'b1;
		reg_wr_data = d;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_regs();
		check("reset image", reg_rd_data, 8'h00);
		wr(8'hff);
		check("image ff", reg_rd_data, 8'hc7);
		check("filter on", wake_filter_on, 8'h01);
		wr(8'h38);
		check("image 38", reg_rd_data, 8'h00);
		check("filter off", wake_filter_on, 8'h00);
	endtask

	task automatic t_aux();
		wr(8'h80);
		aux_clock_enable = 1'b0;
		frame_start = 1'b1;
		cyc(3);
		check("pin disabled", aux_clock_pin, 8'h00);
		aux_clock_enable = 1'b1;
		for (int i = 0; i < 6; i++) begin
			frame_start = i[0] ^ i[1];
			cyc(1);
			check("pin sof", aux_clock_pin, {7'h00, i[0] ^ i[1]});
		end
		wr(8'h00);
		cyc(3);
		prev = aux_clock_pin;
		for (int i = 0; i < 6; i++) begin
			cyc(1);
			check("pin clock", aux_clock_pin, {7'h00, ~prev});
			prev = aux_clock_pin;
		end
		aux_clock_enable = 1'b0;
	endtask

	task automatic t_phase();
		for (int len = 0; len < 8; len++) begin
			wr(len[7:0]);
			phase_two_start = 1'b1;
			cyc(1);
			phase_two_start = 1'b0;
			check("active start", phase_two_active, 8'h01);
			// Done rises at the edge that takes the last of len plus one ticks.
			for (int t = 0; t <= len; t++) begin
				check("done early", phase_two_done, 8'h00);
				time_quantum_tick = 1'b1;
				cyc(1);
				time_quantum_tick = 1'b0;
				if (t < len)
					cyc(1);
			end
			check("done", phase_two_done, 8'h01);
			check("active end", phase_two_active, 8'h00);
			cyc(1);
			check("done pulse", phase_two_done, 8'h00);
		end
	endtask

	task automatic t_wake();
		wr(8'h00);
		wake_pin = 1'b1;
		cyc(1);
		check("wake early", wake_detect, 8'h00);
		cyc(3);
		check("wake raw", wake_detect, 8'h01);
		wake_pin = 1'b0;
		cyc(4);
		wr(8'h40);
		cyc(2);
		wake_pin = 1'b1;
		cyc(1);
		wake_pin = 1'b0;
		cyc(2);
		check("glitch blocked", wake_detect, 8'h00);
		cyc(8);
		check("glitch held off", wake_detect, 8'h00);
		wake_pin = 1'b1;
		cyc(4);
		check("wake filtering", wake_detect, 8'h00);
		cyc(1);
		check("wake filtered", wake_detect, 8'h01);
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= 3000) begin
			num_errors++;
			summarize();
		end
	end

	initial begin
		rst = 1'b1;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		aux_clock_enable = 1'b0;
		frame_start = 1'b0;
		wake_pin = 1'b0;
		time_quantum_tick = 1'b0;
		phase_two_start = 1'b0;
		num_errors = 0;
		n_checks = 0;
		cycles = 0;
		cyc(3);
		rst = 1'b0;
		cyc(1);
		t_regs();
		t_aux();
		t_phase();
		t_wake();
		summarize();
	end
endmodule
